// >>> i2cs_top.sv
// Contract
// - Matching address in first frame: ack low on ninth clock, set irq flag.
// - Irq flag set with irq enable high raises the interrupt output.
// - Read/write bit one sets transmit select and enters slave transmit.
// - Entering transmit sets tx empty and holds SCL low until data written.
// - Data write clears tx empty; load to shifter sets empty, irq, end again.
// - Irq flag sets at the rise of the ninth transmit clock.
// - Tx empty at frame end: stretch SCL low until new data written.
// - Master acknowledge bit is stored in the ack status bit.
// - Tx empty clear at frame end: load buffered byte, set flags again.
// - Stop condition clears the bus busy flag.
// - Irq set moment depends on wait mode and the format selects; here on wait mode in receive only, the format selects just gate the address compare.
// - Tx empty or rx full after a frame holds SCL low, clock synchronous.
// - Start condition sets the bus busy flag.
// - Rx full already set: hold SCL low until data register read.
// - Data read plus irq flag clear clears rx full.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module i2cs_top
  import i2cs_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic irqOut
);
  logic regWr;
  logic [7:0] regWrAddr;
  logic [31:0] regWrData;
  logic [3:0] regWrStrb;
  logic regWrErr;
  logic regRd;
  logic [7:0] regRdAddr;
  logic [31:0] regRdData;
  logic regRdErr;
  logic [1:0] pinSync;
  logic sclS;
  logic sdaS;
  logic sclPrev;
  logic sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic wrCtrl;
  logic wrStat;
  logic wrData;
  logic wrAddrReg;
  logic rdData;
  i2cs_state_e state;
  i2cs_state_e next_state;
  logic ifEnable, irqEnable, masterSel, txSel, busBusy, irqFlag, waitMode, xferEnd;
  logic next_ifEnable, next_irqEnable, next_masterSel, next_txSel;
  logic next_busBusy, next_irqFlag, next_waitMode, next_xferEnd;
  logic ackStatus, txEmpty, rxFull, rxReadSeen;
  logic next_ackStatus, next_txEmpty, next_rxFull, next_rxReadSeen;
  logic [15:0] ownAddr;
  logic [15:0] next_ownAddr;
  logic [7:0] txBuf, txShift, rxShift, rxData;
  logic [7:0] next_txBuf, next_txShift, next_rxShift, next_rxData;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic next_sclOe;
  logic next_sdaOe;
  logic next_irqOut;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0])
      res[7:0] = wd[7:0];
    if (strb[1])
      res[15:8] = wd[15:8];
    return res;
  endfunction

  // address compare, disabled by its format select
  function automatic logic addrMatch(input logic [6:0] got,
                                     input logic [6:0] mine,
                                     input logic fmtSel);
    return (~fmtSel) & (got == mine);
  endfunction

  i2cs_axil u_axil (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regWr(regWr),
    .regWrAddr(regWrAddr),
    .regWrData(regWrData),
    .regWrStrb(regWrStrb),
    .regWrErr(regWrErr),
    .regRd(regRd),
    .regRdAddr(regRdAddr),
    .regRdData(regRdData),
    .regRdErr(regRdErr)
  );

  i2cs_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d({sclIn, sdaIn}),
    .q(pinSync)
  );

  // bus line edges and conditions
  assign sclS = pinSync[1];
  assign sdaS = pinSync[0];
  assign sclRise = sclS & ~sclPrev;
  assign sclFall = ~sclS & sclPrev;
  assign startDet = sclS & sclPrev & sdaPrev & ~sdaS;
  assign stopDet = sclS & sclPrev & ~sdaPrev & sdaS;

  // register decode
  assign wrCtrl = regWr & (regWrAddr == OFF_CTRL) & regWrStrb[0];
  assign wrStat = regWr & (regWrAddr == OFF_STAT) & regWrStrb[0];
  assign wrData = regWr & (regWrAddr == OFF_DATA) & regWrStrb[0];
  assign wrAddrReg = regWr & (regWrAddr == OFF_ADDR);
  assign rdData = regRd & (regRdAddr == OFF_DATA);
  assign regWrErr = ~((regWrAddr == OFF_CTRL) | (regWrAddr == OFF_STAT) |
                      (regWrAddr == OFF_DATA) | (regWrAddr == OFF_ADDR));

  // read mux; unmapped answers error with zero data
  always_comb
  begin
    regRdData = WORD_ZERO;
    regRdErr = 1'b0;
    case (regRdAddr)
      OFF_CTRL:
      begin
        regRdData[CTRL_ENABLE] = ifEnable;
        regRdData[CTRL_IRQ_EN] = irqEnable;
        regRdData[CTRL_MASTER] = masterSel;
        regRdData[CTRL_TXSEL] = txSel;
        regRdData[CTRL_BUSY] = busBusy;
        regRdData[CTRL_IRQ] = irqFlag;
        regRdData[CTRL_WAIT] = waitMode;
        regRdData[CTRL_XEND] = xferEnd;
      end
      OFF_STAT:
      begin
        regRdData[STAT_ACK] = ackStatus;
        regRdData[STAT_TXEMPTY] = txEmpty;
        regRdData[STAT_RXFULL] = rxFull;
      end
      OFF_DATA: regRdData[7:0] = rxData;
      OFF_ADDR: regRdData[15:0] = ownAddr;
      default: regRdErr = 1'b1;
    endcase
  end

  // software writes first, then bus events so that hardware sets win, except tx empty, which yields to a same-cycle data write
  always_comb
  begin
    next_state = state;
    next_ifEnable = ifEnable;
    next_irqEnable = irqEnable;
    next_masterSel = masterSel;
    next_txSel = txSel;
    next_busBusy = busBusy;
    next_irqFlag = irqFlag;
    next_waitMode = waitMode;
    next_xferEnd = xferEnd;
    next_ackStatus = ackStatus;
    next_txEmpty = txEmpty;
    next_rxFull = rxFull;
    next_rxReadSeen = rxReadSeen;
    next_ownAddr = ownAddr;
    next_txBuf = txBuf;
    next_txShift = txShift;
    next_rxShift = rxShift;
    next_rxData = rxData;
    next_bitCnt = bitCnt;
    next_sclOe = sclOe;
    next_sdaOe = sdaOe;
    if (wrCtrl)
    begin
      next_ifEnable = regWrData[CTRL_ENABLE];
      next_irqEnable = regWrData[CTRL_IRQ_EN];
      next_masterSel = regWrData[CTRL_MASTER];
      next_txSel = regWrData[CTRL_TXSEL];
      next_waitMode = regWrData[CTRL_WAIT];
      if (!regWrData[CTRL_IRQ])
        next_irqFlag = 1'b0;
      if (!regWrData[CTRL_XEND])
        next_xferEnd = 1'b0;
    end
    if (wrStat)
      next_ackStatus = regWrData[STAT_ACK];
    if (wrAddrReg)
      next_ownAddr = mergeBytes(ownAddr, regWrData, regWrStrb);
    if (wrData)
    begin
      next_txBuf = regWrData[7:0];
      next_txEmpty = 1'b0;
    end
    if (rdData)
      next_rxReadSeen = 1'b1;
    if (rxReadSeen && !irqFlag)
    begin
      next_rxFull = 1'b0;
      next_rxReadSeen = 1'b0;
    end
    if (startDet)
      next_busBusy = 1'b1;
    if (stopDet)
      next_busBusy = 1'b0;
    if (!ifEnable)
    begin
      next_state = ST_IDLE;
      next_sclOe = 1'b0;
      next_sdaOe = 1'b0;
      next_txEmpty = 1'b0;
      next_rxFull = 1'b0;
    end
    else if (stopDet)
    begin
      next_state = ST_IDLE;
      next_sclOe = 1'b0;
      next_sdaOe = 1'b0;
    end
    else if (startDet)
    begin
      next_state = ST_ADDR;
      next_bitCnt = 4'h0;
      next_sclOe = 1'b0;
      next_sdaOe = 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE: next_sdaOe = 1'b0;
        ST_ADDR:
        begin
          if (sclRise)
          begin
            next_rxShift = {rxShift[6:0], sdaS};
            next_bitCnt = bitCnt + 4'h1;
          end
          if (sclFall && bitCnt == FRAME_BITS)
          begin
            if (addrMatch(rxShift[7:1], ownAddr[ADDR_PRI_LSB +: 7], ownAddr[ADDR_FS_BIT]) ||
                addrMatch(rxShift[7:1], ownAddr[ADDR_SEC_LSB +: 7], ownAddr[ADDR_FSX_BIT]))
            begin
              next_sdaOe = 1'b1;
              next_txSel = rxShift[0];
              next_state = ST_ADDR_ACK;
            end
            else
              next_state = ST_IDLE;
          end
        end
        ST_ADDR_ACK:
        begin
          if (sclRise)
            next_irqFlag = 1'b1;
          if (sclFall)
          begin
            next_sdaOe = 1'b0;
            next_bitCnt = 4'h0;
            if (txSel)
            begin
              next_state = ST_TX_LOAD;
              next_sclOe = 1'b1;
              if (!wrData)
                next_txEmpty = 1'b1;
            end
            else
              next_state = ST_RX_BIT;
          end
        end
        ST_TX_LOAD:
        begin
          if (!txEmpty && !wrData)
          begin
            next_txShift = txBuf;
            next_txEmpty = 1'b1;
            next_irqFlag = 1'b1;
            next_xferEnd = 1'b1;
            next_sdaOe = ~txBuf[7];
            next_sclOe = 1'b0;
            next_bitCnt = 4'h0;
            next_state = ST_TX_BIT;
          end
          else
            next_sclOe = 1'b1;
        end
        ST_TX_BIT:
        begin
          if (sclRise)
            next_bitCnt = bitCnt + 4'h1;
          if (sclFall)
          begin
            if (bitCnt == FRAME_BITS)
            begin
              next_sdaOe = 1'b0;
              next_state = ST_TX_ACK;
            end
            else
            begin
              next_txShift = {txShift[6:0], 1'b1};
              next_sdaOe = ~txShift[6];
            end
          end
        end
        ST_TX_ACK:
        begin
          if (sclRise)
          begin
            next_ackStatus = sdaS;
            next_irqFlag = 1'b1;
          end
          if (sclFall)
          begin
            next_sclOe = txEmpty;
            next_state = ST_TX_LOAD;
          end
        end
        ST_RX_BIT:
        begin
          if (sclRise)
          begin
            next_rxShift = {rxShift[6:0], sdaS};
            next_bitCnt = bitCnt + 4'h1;
          end
          if (sclFall && bitCnt == FRAME_BITS)
          begin
            if (waitMode)
              next_irqFlag = 1'b1;
            if (rxFull)
            begin
              next_sclOe = 1'b1;
              next_state = ST_RX_HOLD;
            end
            else
            begin
              next_rxData = rxShift;
              next_rxFull = 1'b1;
              next_sdaOe = ~ackStatus;
              next_state = ST_RX_ACK;
            end
          end
        end
        ST_RX_HOLD:
        begin
          if (!rxFull)
          begin
            next_rxData = rxShift;
            next_rxFull = 1'b1;
            next_sdaOe = ~ackStatus;
            next_sclOe = 1'b0;
            next_state = ST_RX_ACK;
          end
          else
            next_sclOe = 1'b1;
        end
        ST_RX_ACK:
        begin
          if (sclRise && !waitMode)
            next_irqFlag = 1'b1;
          if (sclFall)
          begin
            next_sdaOe = 1'b0;
            next_bitCnt = 4'h0;
            next_state = ST_RX_BIT;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
    next_irqOut = next_irqFlag & next_irqEnable;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      ifEnable <= 1'b0;
      irqEnable <= 1'b0;
      masterSel <= 1'b0;
      txSel <= 1'b0;
      busBusy <= 1'b0;
      irqFlag <= 1'b0;
      waitMode <= 1'b0;
      xferEnd <= 1'b0;
      ackStatus <= 1'b0;
      txEmpty <= 1'b0;
      rxFull <= 1'b0;
      rxReadSeen <= 1'b0;
      ownAddr <= ADDR_RST;
      txBuf <= BYTE_ZERO;
      txShift <= BYTE_ZERO;
      rxShift <= BYTE_ZERO;
      rxData <= BYTE_ZERO;
      bitCnt <= 4'h0;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      irqOut <= 1'b0;
    end
    else
    begin
      state <= next_state;
      sclPrev <= sclS;
      sdaPrev <= sdaS;
      ifEnable <= next_ifEnable;
      irqEnable <= next_irqEnable;
      masterSel <= next_masterSel;
      txSel <= next_txSel;
      busBusy <= next_busBusy;
      irqFlag <= next_irqFlag;
      waitMode <= next_waitMode;
      xferEnd <= next_xferEnd;
      ackStatus <= next_ackStatus;
      txEmpty <= next_txEmpty;
      rxFull <= next_rxFull;
      rxReadSeen <= next_rxReadSeen;
      ownAddr <= next_ownAddr;
      txBuf <= next_txBuf;
      txShift <= next_txShift;
      rxShift <= next_rxShift;
      rxData <= next_rxData;
      bitCnt <= next_bitCnt;
      sclOe <= next_sclOe;
      sdaOe <= next_sdaOe;
      sclOut <= 1'b0; // open drain: only ever drives low
      sdaOut <= 1'b0;
      irqOut <= next_irqOut;
    end
  end
endmodule
`default_nettype wire

// >>> i2cs_pkg.sv
`default_nettype none
package i2cs_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_ADDR = 8'h0c;
  // control register bit positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_IRQ_EN = 1;
  localparam int CTRL_MASTER = 2;
  localparam int CTRL_TXSEL = 3;
  localparam int CTRL_BUSY = 4;
  localparam int CTRL_IRQ = 5;
  localparam int CTRL_WAIT = 6;
  localparam int CTRL_XEND = 7;
  // status register bit positions
  localparam int STAT_ACK = 0;
  localparam int STAT_TXEMPTY = 1;
  localparam int STAT_RXFULL = 2;
  // slave address register layout
  localparam int ADDR_PRI_LSB = 0;
  localparam int ADDR_FS_BIT = 7;
  localparam int ADDR_SEC_LSB = 8;
  localparam int ADDR_FSX_BIT = 15;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // frame and bus constants
  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_TX_LOAD = 4'b0011,
    ST_TX_BIT = 4'b0100,
    ST_TX_ACK = 4'b0101,
    ST_RX_BIT = 4'b0110,
    ST_RX_ACK = 4'b0111,
    ST_RX_HOLD = 4'b1000
  } i2cs_state_e;
endpackage
`default_nettype wire

// >>> i2cs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module i2cs_sync
  import i2cs_pkg::*;
#(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
)(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  // two flops, the first read only by the second
  always_comb
  begin
    next_stage1 = d;
    next_q = stage1;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      stage1 <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      stage1 <= next_stage1;
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// >>> i2cs_axil.sv
`timescale 1ns/1ps
`default_nettype none
module i2cs_axil
  import i2cs_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic regWr,
  output logic [7:0] regWrAddr,
  output logic [31:0] regWrData,
  output logic [3:0] regWrStrb,
  input wire logic regWrErr,
  output logic regRd,
  output logic [7:0] regRdAddr,
  input wire logic [31:0] regRdData,
  input wire logic regRdErr
);
  logic awHave;
  logic wHave;
  logic next_awHave;
  logic next_wHave;
  logic [7:0] next_regWrAddr;
  logic [31:0] next_regWrData;
  logic [3:0] next_regWrStrb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // read strobe at the address handshake
  assign regRd = arvalid & arready;
  assign regRdAddr = araddr;
  // write strobe once address and data are both held
  assign regWr = awHave & wHave & ~bvalid;

  // write channel: address and data taken in either order
  always_comb
  begin
    next_awHave = awHave;
    next_wHave = wHave;
    next_regWrAddr = regWrAddr;
    next_regWrData = regWrData;
    next_regWrStrb = regWrStrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (awvalid && awready)
    begin
      next_awHave = 1'b1;
      next_regWrAddr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_wHave = 1'b1;
      next_regWrData = wdata;
      next_regWrStrb = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (regWr)
    begin
      next_awHave = 1'b0;
      next_wHave = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = regWrErr ? RESP_SLVERR : RESP_OKAY;
    end
    next_awready = ~next_awHave;
    next_wready = ~next_wHave;
  end

  // read channel: one read under way at a time
  always_comb
  begin
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready)
    begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (regRd)
    begin
      next_rvalid = 1'b1;
      next_arready = 1'b0;
      next_rdata = regRdData;
      next_rresp = regRdErr ? RESP_SLVERR : RESP_OKAY;
    end
    // reopen the address channel once no answer is pending
    if (!arready && !next_rvalid)
      next_arready = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      regWrAddr <= BYTE_ZERO;
      regWrData <= WORD_ZERO;
      regWrStrb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= WORD_ZERO;
      rresp <= RESP_OKAY;
    end
    else
    begin
      awHave <= next_awHave;
      wHave <= next_wHave;
      regWrAddr <= next_regWrAddr;
      regWrData <= next_regWrData;
      regWrStrb <= next_regWrStrb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule
`default_nettype wire

// >>> i2cs_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module i2cs_top_asserts
  import i2cs_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // pins only ever pull low
  property p_out_zero;
    !sclOut && !sdaOut;
  endproperty
  a_out_zero: assert property (p_out_zero) else $error("pin data not low");
  // data line moves only in the low clock phase
  property p_sda_low;
    $changed(sdaOe) |-> !sclIn;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda moved while scl high");
  // stretch starts after the clock has fallen
  property p_stretch;
    $rose(sclOe) |-> !sclIn;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch on high scl");
  // write answer follows both items
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_b_ans;
    ##[2:3] bvalid;
  endsequence
  property p_wr_ans;
    s_wr_taken |-> s_b_ans;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  // responses stand until taken; reads answered next cycle, one at a time
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_rd_ans;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_ar_ref;
    rvalid |-> !arready;
  endproperty
  a_ar_ref: assert property (p_ar_ref) else $error("read taken while busy");
endmodule
bind i2cs_top i2cs_top_asserts u_i2cs_top_asserts (.mclk, .sys_rst, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid,
  .rready, .sclIn, .sclOut, .sclOe, .sdaOut, .sdaOe);
`default_nettype wire

// >>> i2cs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2cs_master_model
(
  input wire logic scl,
  input wire logic sda,
  output logic sclM,
  output logic sdaM
);
  // bus idles released
  initial
  begin
    sclM = 1'b1;
    sdaM = 1'b1;
  end
  // one clock pulse, waits out stretching
  task automatic pulse(output logic b);
    #78 sclM = 1'b1;
    wait (scl === 1'b1);
    #40 b = sda;
    #40 sclM = 1'b0;
    #2; // data hold after the clock falls
  endtask
  task automatic start();
    #3 sdaM = 1'b0;
    #80 sclM = 1'b0;
    #2;
  endtask
  task automatic stop();
    sdaM = 1'b0;
    #80 sclM = 1'b1;
    #80 sdaM = 1'b1;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--)
    begin
      sdaM = d[i];
      pulse(x);
    end
    sdaM = 1'b1;
    pulse(ack);
  endtask
  task automatic rbyte(output logic [7:0] d, input logic ack);
    logic x;
    for (int i = 7; i >= 0; i--)
      pulse(d[i]);
    sdaM = ack;
    pulse(x);
    sdaM = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> test_i2c_slave_transmit_path.sv
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_transmit_path
  import i2cs_pkg::*;
;
  logic mclk = 1'b0, sys_rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h25b4c439;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, sclOut, sclOe, sdaOut, sdaOe, irqOut;
  logic sclM, sdaM;
  wire logic scl = sclM & ~sclOe;
  wire logic sda = sdaM & ~sdaOe;
  int num_errors = 0, compares = 0;
  logic [7:0] txq [$];
  always #2.5 mclk = ~mclk;
  i2cs_top u_i2cs_top (.mclk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .sclIn(scl), .sclOut, .sclOe, .sdaIn(sda), .sdaOut,
    .sdaOe, .irqOut);
  i2cs_master_model u_i2cs_master_model (.scl, .sda, .sclM, .sdaM);
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // bus write, each item released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge mclk);
      if (!aw && awready === 1'b1)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // hang guard
  initial
  begin
    #200000;
    num_errors++;
    test_done();
  end
  // main sequence
  initial
  begin
    logic [31:0] rd;
    logic [1:0] rs;
    logic ack;
    logic [7:0] b;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    axr(OFF_CTRL, rd, rs);
    chk("ctrl reset", rd, WORD_ZERO);
    axr(8'h10, rd, rs);
    chk("unmapped", rs, RESP_SLVERR);
    axw(8'h10, WORD_ZERO);
    chk("wr unmapped", bresp, RESP_SLVERR);
    axw(OFF_ADDR, 32'h0000002a);
    axw(OFF_CTRL, 32'h00000003);
    $display("test regs done");
    u_i2cs_master_model.start();
    u_i2cs_master_model.wbyte(8'h55, ack);
    chk("addr ack", ack, 1'b0);
    repeat (8) @(posedge mclk);
    chk("stretch", sclOe, 1'b1);
    chk("irq", irqOut, 1'b1);
    axr(OFF_CTRL, rd, rs);
    chk("ctrl", rd, 32'h0000003b);
    axr(OFF_STAT, rd, rs);
    chk("tx empty", rd[STAT_TXEMPTY], 1'b1);
    $display("test address done");
    axw(OFF_CTRL, 32'h0000000b);
    txq.push_back(rnd());
    axw(OFF_DATA, txq[0]);
    fork
      u_i2cs_master_model.rbyte(b, 1'b0);
      begin
        axw(OFF_CTRL, 32'h0000000b);
        repeat (4) @(posedge mclk);
        chk("irq clear", irqOut, 1'b0);
      end
    join
    chk("byte", b, txq.pop_front());
    repeat (8) @(posedge mclk);
    chk("irq frame", irqOut, 1'b1);
    chk("stretch end", sclOe, 1'b1);
    axr(OFF_STAT, rd, rs);
    chk("stat ack", rd[2:0], 3'h2);
    txq.push_back(rnd());
    axw(OFF_DATA, txq[0]);
    fork
      u_i2cs_master_model.rbyte(b, 1'b1);
      axw(OFF_DATA, 32'h000000ff);
    join
    chk("byte", b, txq.pop_front());
    repeat (8) @(posedge mclk);
    chk("sda free", sdaOe, 1'b0);
    u_i2cs_master_model.stop();
    repeat (8) @(posedge mclk);
    axr(OFF_STAT, rd, rs);
    chk("stat nack", rd[STAT_ACK], 1'b1);
    chk("ff loaded", rd[STAT_TXEMPTY], 1'b1);
    axr(OFF_CTRL, rd, rs);
    chk("busy", rd[CTRL_BUSY], 1'b0);
    chk("xfer end", rd[CTRL_XEND], 1'b1);
    $display("test transmit done");
    axw(OFF_STAT, WORD_ZERO);
    u_i2cs_master_model.start();
    u_i2cs_master_model.wbyte(8'h54, ack);
    chk("rx addr ack", ack, 1'b0);
    b = rnd();
    u_i2cs_master_model.wbyte(b, ack);
    chk("rx ack", ack, 1'b0);
    axr(OFF_STAT, rd, rs);
    chk("rx full", rd[STAT_RXFULL], 1'b1);
    axr(OFF_DATA, rd, rs);
    chk("rx data", rd[7:0], b);
    axw(OFF_CTRL, 32'h00000003);
    axr(OFF_STAT, rd, rs);
    chk("rx full clear", rd[STAT_RXFULL], 1'b0);
    u_i2cs_master_model.stop();
    $display("test receive done");
    test_done();
  end
endmodule
`default_nettype wire
